// ### inc/seu_entry_if.sv
// Entry request bundle from the prioritiser to the main unit.
interface seu_entry_if;
  import seu_pkg::*;
  logic       take;
  logic [4:0] mode;
  logic [7:0] offset;
  logic       set_fmask;
  modport source (output take, output mode, output offset, output set_fmask);
  modport sink   (input take, input mode, input offset, input set_fmask);
endinterface : seu_entry_if

// ### inc/seu_pkg.sv
// Shared constants and types for the status and exception unit.
package seu_pkg;

  // Mode field encodings.
  localparam logic [4:0] MODE_USER        = 5'h10;
  localparam logic [4:0] MODE_FAST_IRQ    = 5'h11;
  localparam logic [4:0] MODE_NORMAL_IRQ  = 5'h12;
  localparam logic [4:0] MODE_SUPERVISOR  = 5'h13;
  localparam logic [4:0] MODE_ABORT       = 5'h17;
  localparam logic [4:0] MODE_BAD_OPCODE  = 5'h1b;
  localparam logic [4:0] MODE_PRIV_OS     = 5'h1f;

  // Status word field positions.
  localparam int PSW_NEG_BIT   = 31;
  localparam int PSW_ZERO_BIT  = 30;
  localparam int PSW_CARRY_BIT = 29;
  localparam int PSW_OVF_BIT   = 28;
  localparam int PSW_IMASK_BIT = 7;
  localparam int PSW_FMASK_BIT = 6;
  localparam int PSW_STATE_BIT = 5;
  localparam logic [31:0] PSW_WRITABLE = 32'hf00000ff;

  // Value after reset: supervisor mode, both masks set, full state.
  localparam logic [31:0] PSW_RESET = 32'h000000d3;

  // Vector table bases and offsets.
  localparam logic [31:0] VEC_BASE_LOW   = 32'h00000000;
  localparam logic [31:0] VEC_BASE_HIGH  = 32'hffff0000;
  localparam logic [7:0]  VEC_RESET      = 8'h00;
  localparam logic [7:0]  VEC_BAD_OPCODE = 8'h04;
  localparam logic [7:0]  VEC_SW_TRAP    = 8'h08;
  localparam logic [7:0]  VEC_PREFETCH   = 8'h0c;
  localparam logic [7:0]  VEC_DATA_ABORT = 8'h10;
  localparam logic [7:0]  VEC_RESERVED   = 8'h14;
  localparam logic [7:0]  VEC_NORMAL_IRQ = 8'h18;
  localparam logic [7:0]  VEC_FAST_IRQ   = 8'h1c;

  // Register offsets of the plain register port.
  localparam logic [3:0] REG_PSW        = 4'h0;
  localparam logic [3:0] REG_SAVED_PSW  = 4'h1;
  localparam logic [3:0] REG_SAVED_PC   = 4'h2;
  localparam logic [3:0] REG_CONTROL    = 4'h3;
  localparam logic [3:0] REG_VECTOR     = 4'h4;
  localparam logic [3:0] REG_STACK_PTR  = 4'h5;
  localparam logic [3:0] REG_BANK_SEL   = 4'h6;
  localparam logic [3:0] REG_BANK_SP    = 4'h7;
  localparam int         CTRL_HIGH_VEC_BIT = 0;
  localparam logic [31:0] CONTROL_RESET  = 32'h00000000;

  // Number of banked modes and exception sources.
  localparam int NUM_BANKS = 7;
  localparam int NUM_SRC   = 7;

  // Exception source index; one bit per source in a request vector.
  typedef enum logic [2:0]
  {
    SRC_RESET = 3'h0,
    SRC_DATA  = 3'h1,
    SRC_FIQ   = 3'h2,
    SRC_IRQ   = 3'h3,
    SRC_PREF  = 3'h4,
    SRC_BAD   = 3'h5,
    SRC_TRAP  = 3'h6
  } seu_src_t;

  // Entry control state, one-hot.
  typedef enum logic [1:0]
  {
    ST_RUN   = 2'b01,
    ST_ENTER = 2'b10
  } seu_state_t;

endpackage : seu_pkg

// ### sim/seu_src_model.sv
// Model of the interrupt controller and the memory abort sources.
module seu_src_model
(
  // Clock.
  input  wire logic       clk,
  // Requests from the bench: normal, fast, prefetch, data.
  input  wire logic [3:0] want,
  // Lines towards the unit.
  output logic            irq,
  output logic            fast_interrupt_request,
  output logic            pabort,
  output logic            dabort
);
  timeunit 1ns;
  timeprecision 1ns;

  // Aborts come from same-clock memory logic, so they follow the request at once.
  assign pabort = want[2];
  assign dabort = want[3];

  // Interrupt lines are re-timed on the edge; the unit synchronises them anyway.
  initial {irq, fast_interrupt_request} = 2'h0;
  always @(posedge clk)
  begin
    irq <= want[0];
    fast_interrupt_request <= want[1];
  end
endmodule : seu_src_model

// ### sim/seu_top_asserts.sv
// Port-level assertions for the status and exception unit.
module seu_top_chk
(
  // Clock and reset.
  input  wire logic        CLOCK,
  input  wire logic        RST,
  // Causes seen at the inputs.
  input  wire logic        WR,
  input  wire logic        ALU_UPDATE,
  input  wire logic [3:0]  ALU_FLAGS,
  input  wire logic        BRANCH_EXCHANGE,
  input  wire logic        BRANCH_TARGET_LSB,
  // Outputs under watch.
  input  wire logic        ENTRY,
  input  wire logic [31:0] VECTOR_ADDR,
  input  wire logic [31:0] PROGRAM_STATUS_WORD,
  input  wire logic        MODE_DENIED
);
  logic [31:0] p;
  logic [7:0]  v;

  // Short aliases keep the properties readable.
  assign p = PROGRAM_STATUS_WORD;
  assign v = VECTOR_ADDR[7:0];

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);

  // The offset of an entry fixes the mode and the mask bits that follow it.
  reset_value_a: assert property (
    $fell(RST) |-> p == 32'h000000d3 && !ENTRY) else $error("status not at reset value");
  entry_imask_a: assert property (
    ENTRY |-> p[7]) else $error("entry left normal mask clear");
  vector_slot_a: assert property (
    ENTRY |-> v != 8'h14 && VECTOR_ADDR[15:8] == 8'h00) else $error("bad vector slot");
  abort_entry_a: assert property (
    ENTRY && (v == 8'h0c || v == 8'h10) |-> p[4:0] == 5'h17 && p[6] == $past(p[6]))
    else $error("abort entry wrong");
  trap_entry_a: assert property (
    ENTRY && v == 8'h08 |-> p[4:0] == 5'h13 && p[6] == $past(p[6]))
    else $error("trap entry wrong");
  bad_entry_a: assert property (
    ENTRY && v == 8'h04 |-> p[4:0] == 5'h1b && p[6] == $past(p[6]))
    else $error("bad opcode entry wrong");
  irq_entry_a: assert property (
    ENTRY && v == 8'h18 |-> p[4:0] == 5'h12 && p[6] == $past(p[6]))
    else $error("normal interrupt entry wrong");
  fiq_entry_a: assert property (
    ENTRY && v == 8'h1c |-> p[4:0] == 5'h11 && p[6]) else $error("fast entry wrong");
  reserved_zero_a: assert property (
    p[27:8] == 20'h0) else $error("reserved status bits set");
  flag_load_a: assert property (
    ALU_UPDATE && !WR |=> p[31:28] == $past(ALU_FLAGS)) else $error("flags not loaded");
  state_switch_a: assert property (
    BRANCH_EXCHANGE && !WR |=> ENTRY || p[5] == $past(BRANCH_TARGET_LSB))
    else $error("state bit not switched");
  user_denied_a: assert property (
    MODE_DENIED |-> $past(p[4:0]) == 5'h10 && (ENTRY || p[7:0] == $past(p[7:0])))
    else $error("denied write changed control bits");
endmodule : seu_top_chk

bind seu_top seu_top_chk chk (.CLOCK(CLOCK), .RST(RST), .WR(WR), .ALU_UPDATE(ALU_UPDATE),
  .ALU_FLAGS(ALU_FLAGS), .BRANCH_EXCHANGE(BRANCH_EXCHANGE), .ENTRY(ENTRY),
  .BRANCH_TARGET_LSB(BRANCH_TARGET_LSB), .VECTOR_ADDR(VECTOR_ADDR),
  .PROGRAM_STATUS_WORD(PROGRAM_STATUS_WORD), .MODE_DENIED(MODE_DENIED));

// ### sim/tb_status_exception_unit.sv
// Self-checking bench for the status and exception unit.
module tb_status_exception_unit
  import seu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        alu_update = 1'b0;
  logic [3:0]  alu_flags = 4'h0;
  logic        bx = 1'b0;
  logic        bx_lsb = 1'b0;
  logic [5:0]  raise = 6'h0;
  logic [31:0] ret_pc = 32'h0;
  logic        irq, fast_interrupt_request, pabort, dabort, entry, denied, hv, seen;
  logic [31:0] rdata, vec, psw, sp, m_psw;
  logic [31:0] r = 32'h80de;
  int          err_count = 0;
  int          total_checks = 0;
  int          cb, i;
  int          sp_m[6] = '{default: 0};
  // Source order: trap, bad opcode, prefetch, data, normal, fast.
  logic [7:0]  vt[6] = '{8'h08, 8'h04, 8'h0c, 8'h10, 8'h18, 8'h1c};
  logic [4:0]  mt[6] = '{5'h13, 5'h1b, 5'h17, 5'h17, 5'h12, 5'h11};
  int          bt[6] = '{3, 5, 4, 4, 2, 1};

  seu_src_model src (.clk(clk), .want({raise[3], raise[2], raise[5], raise[4]}), .irq(irq),
    .fast_interrupt_request(fast_interrupt_request), .pabort(pabort), .dabort(dabort));
  seu_top uut (.CLOCK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .NORMAL_IRQ(irq), .FAST_IRQ(fast_interrupt_request), .PREFETCH_ABORT(pabort),
    .DATA_ABORT(dabort), .SOFTWARE_TRAP(raise[0]), .BAD_OPCODE(raise[1]), .RETURN_PC(ret_pc),
    .ALU_UPDATE(alu_update), .ALU_FLAGS(alu_flags), .BRANCH_EXCHANGE(bx),
    .BRANCH_TARGET_LSB(bx_lsb), .ENTRY(entry), .VECTOR_ADDR(vec), .PROGRAM_STATUS_WORD(psw),
    .STACK_POINTER(sp), .MODE_DENIED(denied));

  // Free-running core clock.
  always #5 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : check

  task automatic close_out;
    if (err_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  // One write; user mode may only touch the flags, and a changed low byte is refused.
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    logic den;
    den = 1'b0;
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    if (a == 4'h5)
      sp_m[cb] = d;
    if (a == 4'h0 && m_psw[4:0] == 5'h10)
    begin
      den = d[7:0] != m_psw[7:0];
      m_psw[31:28] = d[31:28];
    end
    else if (a == 4'h0)
    begin
      m_psw = d & 32'hf00000ff;
      cb = (d[4:0] == 5'h13) ? 3 : 0;
    end
    #1 check({31'h0, denied}, {31'h0, den});
    check(psw, m_psw);
    check(sp, sp_m[cb]);
    @(posedge clk);
  endtask : wreg

  // One read; data stand only in the cycle after the strobe.
  task automatic rreg(input logic [3:0] a, input logic [31:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, e);
    @(posedge clk);
  endtask : rreg

  // Raise a set of sources and expect the entry of source s within a bounded wait.
  task automatic enter(input logic [5:0] m, input int s);
    logic [31:0] prior;
    prior = m_psw;
    raise <= m;
    for (int k = 0; k < 20 && entry !== 1'b1; k++)
    begin
      @(posedge clk);
      #1;
    end
    if (entry !== 1'b1)
    begin
      err_count++;
      close_out();
    end
    m_psw = (prior & 32'hf0000040) | 32'h80 | {27'h0, mt[s]} | ((s == 5) ? 32'h40 : 32'h0);
    cb = bt[s];
    check(psw, m_psw);
    check(vec, (hv ? 32'hffff0000 : 32'h0) | {24'h0, vt[s]});
    check(sp, sp_m[cb]);
    @(posedge clk);
    raise <= 6'h0;
    repeat (5) @(posedge clk);
    rreg(4'h1, prior);
    rreg(4'h2, ret_pc);
  endtask : enter

  // Main sequence.
  initial
  begin
    hv = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    m_psw = 32'h000000d3;
    cb = 3;
    #1 check(psw, m_psw);
    check(vec, 32'h0);
    @(posedge clk);
    rreg(4'h0, 32'h000000d3);
    wreg(4'h0, 32'h5aa5a5d3);
    rreg(4'h0, 32'h500000d3);
    rreg(4'h9, 32'h0);
    wreg(4'h9, 32'hffffffff);
    for (i = 0; i < 4; i++)
    begin
      r = lfsr(r);
      alu_update <= 1'b1;
      alu_flags <= r[3:0];
      bx <= 1'b1;
      bx_lsb <= r[4];
      @(posedge clk);
      alu_update <= 1'b0;
      bx <= 1'b0;
      m_psw[31:28] = r[3:0];
      m_psw[5] = r[4];
      #1 check(psw, m_psw);
      @(posedge clk);
    end
    wreg(4'h0, 32'h000000d0);
    raise <= 6'h30;
    seen = 1'b0;
    repeat (10)
    begin
      @(posedge clk);
      #1 seen = seen | entry;
    end
    check({31'h0, seen}, 32'h0);
    raise <= 6'h0;
    repeat (6) @(posedge clk);
    for (i = 0; i < 6; i++)
    begin
      r = lfsr(r);
      ret_pc <= r;
      hv = (i == 3);
      wreg(4'h3, {31'h0, hv});
      wreg(4'h0, {r[31:28], 28'h10});
      wreg(4'h5, lfsr(r));
      enter(6'h01 << i, i);
      wreg(4'h5, r ^ 32'h5a5a5a5a);
    end
    hv = 1'b0;
    wreg(4'h3, 32'h0);
    rreg(4'h3, 32'h0);
    rreg(4'h4, 32'h0000001c);
    wreg(4'h6, 32'h1);
    rreg(4'h6, 32'h1);
    rreg(4'h7, sp_m[1]);
    wreg(4'h0, 32'h0000001f);
    wreg(4'h0, 32'h00000090);
    enter(6'h1f, 3);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    #1 check(psw, 32'h000000d3);
    close_out();
  end
endmodule : tb_status_exception_unit

// ### src/seu_bank.sv
// Per-mode banked stack pointers, saved status words and return addresses.
module seu_bank
  import seu_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  // Save port, used on exception entry.
  input  wire logic        save,
  input  wire logic [2:0]  save_idx,
  input  wire logic [31:0] save_psw,
  input  wire logic [31:0] save_pc,
  // Stack pointer write port.
  input  wire logic        sp_we,
  input  wire logic [2:0]  sp_idx,
  input  wire logic [31:0] sp_wdata,
  // Read ports.
  input  wire logic [2:0]  rd_idx,
  output logic      [31:0] rd_sp,
  output logic      [31:0] rd_psw,
  output logic      [31:0] rd_pc,
  input  wire logic [2:0]  aux_idx,
  output logic      [31:0] aux_sp
);
  logic [31:0] sp_mem  [NUM_BANKS];
  logic [31:0] psw_mem [NUM_BANKS];
  logic [31:0] pc_mem  [NUM_BANKS];

  // One bank per mode; each entry updates on its own index.
  for (genvar g = 0; g < NUM_BANKS; g++)
  begin : g_bank
    always_ff @(posedge clk)
    begin
      if (rst)
      begin
        sp_mem[g]  <= '0;
        psw_mem[g] <= '0;
        pc_mem[g]  <= '0;
      end
      else
      begin
        if (sp_we && sp_idx == 3'(g))
          sp_mem[g] <= sp_wdata;
        if (save && save_idx == 3'(g))
        begin
          psw_mem[g] <= save_psw;
          pc_mem[g]  <= save_pc;
        end
      end
    end
  end

  // Out-of-range indices read as zero.
  always_comb
  begin
    rd_sp  = (rd_idx  < 3'(NUM_BANKS)) ? sp_mem[rd_idx]  : '0;
    rd_psw = (rd_idx  < 3'(NUM_BANKS)) ? psw_mem[rd_idx] : '0;
    rd_pc  = (rd_idx  < 3'(NUM_BANKS)) ? pc_mem[rd_idx]  : '0;
    aux_sp = (aux_idx < 3'(NUM_BANKS)) ? sp_mem[aux_idx] : '0;
  end
endmodule : seu_bank

// ### src/seu_prio.sv
// Fixed-priority selector of pending exceptions.
module seu_prio
  import seu_pkg::*;
(
  // Pending sources, indexed by seu_src_t.
  input  wire logic [NUM_SRC-1:0] pend,
  // Chosen entry.
  seu_entry_if.source             ent
);
  // Lowest index wins; the trap and bad opcode cannot both be pending.
  always_comb
  begin
    ent.take      = |pend;
    ent.mode      = MODE_SUPERVISOR;
    ent.offset    = VEC_RESET;
    ent.set_fmask = 1'b0;
    if (pend[SRC_RESET])
    begin
      ent.set_fmask = 1'b1;
    end
    else if (pend[SRC_DATA])
    begin
      ent.mode   = MODE_ABORT;
      ent.offset = VEC_DATA_ABORT;
    end
    else if (pend[SRC_FIQ])
    begin
      ent.mode      = MODE_FAST_IRQ;
      ent.offset    = VEC_FAST_IRQ;
      ent.set_fmask = 1'b1;
    end
    else if (pend[SRC_IRQ])
    begin
      ent.mode   = MODE_NORMAL_IRQ;
      ent.offset = VEC_NORMAL_IRQ;
    end
    else if (pend[SRC_PREF])
    begin
      ent.mode   = MODE_ABORT;
      ent.offset = VEC_PREFETCH;
    end
    else if (pend[SRC_BAD])
    begin
      ent.mode   = MODE_BAD_OPCODE;
      ent.offset = VEC_BAD_OPCODE;
    end
    else if (pend[SRC_TRAP])
    begin
      ent.offset = VEC_SW_TRAP;
    end
  end
endmodule : seu_prio

// ### src/seu_top.sv
// Status word and exception entry unit of the processor core.
// Functional notes
// - Mode codes for user, fast, normal interrupt
// - Mode codes for supervisor and abort
// - Mode codes for bad opcode, privileged OS
// - Bit 7 masks normal interrupts
// - Bit 6 masks fast interrupts
// - Bit 5 selects compact instruction state
// - Bits 27:8 reserved, flags in 31:28
// - Flags follow latest arithmetic result
// - Fixed exception priority order
// - High vector select picks table base
// - Reset: offset 0, supervisor, both masks
// - Bad opcode: 04h, its mode, normal mask
// - Software trap: 08h, supervisor, normal mask
// - Aborts: 0Ch prefetch, 10h data
// - Offset 14h never used
// - Normal interrupt: 18h, its mode, mask
// - Fast interrupt: 1Ch, both masks set
// - Privileged modes entered only from privileged
// - Banked stack pointer per mode; here user and privileged OS share one bank
// - Branch exchange switches instruction state
// - Memory aborts raise prefetch or data abort
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
module seu_top
  import seu_pkg::*;
(
  // Clock and reset.
  input  wire logic        CLOCK,
  input  wire logic        RST,
  // Register port.
  input  wire logic [3:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  // Exception sources.
  input  wire logic        NORMAL_IRQ,
  input  wire logic        FAST_IRQ,
  input  wire logic        PREFETCH_ABORT,
  input  wire logic        DATA_ABORT,
  input  wire logic        SOFTWARE_TRAP,
  input  wire logic        BAD_OPCODE,
  input  wire logic [31:0] RETURN_PC,
  // Core execution inputs.
  input  wire logic        ALU_UPDATE,
  input  wire logic [3:0]  ALU_FLAGS,
  input  wire logic        BRANCH_EXCHANGE,
  input  wire logic        BRANCH_TARGET_LSB,
  // Exception entry outputs.
  output logic             ENTRY,
  output logic      [31:0] VECTOR_ADDR,
  output logic      [31:0] PROGRAM_STATUS_WORD,
  output logic      [31:0] STACK_POINTER,
  output logic             MODE_DENIED
);
  import seu_pkg::*;

  // Whole state of the unit.
  // Everything that the unit remembers outside the banks lives in this one
  // structure. The combinational block below builds the next copy from the
  // current one, and a single clocked block registers it. Keeping all state
  // in one place makes the reset values easy to audit and guarantees that
  // every register runs on every clock edge without a separate enable.
  // The two interrupt lines arrive from another timing domain, so their
  // metastability and synchroniser stages are part of the same structure.
  // The status word holds flags in the top nibble, reserved zeros in the
  // middle and the control byte at the bottom; reserved bits are masked on
  // every software write so they can never be set.
  typedef struct packed
  {
    seu_state_t  state;
    logic [31:0] psw;
    logic [31:0] control;
    logic [31:0] vector;
    logic [2:0]  bank_sel;
    logic [31:0] rdata;
    logic        entry;
    logic        denied;
    logic [1:0]  irq_sync;
    logic [1:0]  fiq_sync;
    logic        irq_meta;
    logic        fiq_meta;
  } seu_regs_t;

  seu_regs_t r;
  seu_regs_t next_r;

  // The prioritiser hands its choice over in one bundle, so the mode, the
  // vector offset and the fast mask decision always travel together and can
  // never be taken from two different sources in one cycle.
  seu_entry_if ent ();

  logic [NUM_SRC-1:0] pend;
  logic [2:0]         cur_idx;
  logic [2:0]         ent_idx;
  logic [31:0]        cur_sp;
  logic [31:0]        cur_spsr;
  logic [31:0]        cur_spc;
  logic [31:0]        aux_sp;
  logic               sp_we;
  logic [2:0]         sp_idx;

  // Map a mode code to its bank; user and privileged OS share one bank.
  // Sharing is deliberate: the privileged OS mode runs on the user stack so
  // that an operating system can inspect user context without copying it.
  // Codes that name no mode fall into the user bank as well; software that
  // writes such a code gets a consistent, if unhelpful, stack pointer rather
  // than an unknown one.
  function automatic logic [2:0] bank_of(input logic [4:0] m);
    case (m)
      MODE_FAST_IRQ:   bank_of = 3'h1;
      MODE_NORMAL_IRQ: bank_of = 3'h2;
      MODE_SUPERVISOR: bank_of = 3'h3;
      MODE_ABORT:      bank_of = 3'h4;
      MODE_BAD_OPCODE: bank_of = 3'h5;
      default:         bank_of = 3'h0;
    endcase
  endfunction : bank_of

  // Any mode other than user counts as privileged.
  // This one test gates every software write of the mode field and the masks, so user
  // code cannot raise its own privilege or hide interrupts from the system.
  function automatic logic is_priv(input logic [4:0] m);
    is_priv = (m != MODE_USER);
  endfunction : is_priv

  // Pending sources; interrupts pass a three-stage synchroniser first.
  // Aborts, traps and bad opcodes come from logic on this clock and are used
  // as they stand. Interrupts are masked after synchronisation, so a mask
  // change takes effect on the very next edge regardless of line history.
  // A trap is dropped while a bad opcode is present: the trap has the lowest
  // priority, the bad opcode ranking just above the trap, and an instruction that cannot be decoded cannot be a trap.
  // The cost of the interrupt synchroniser is three cycles of added latency.
  always_comb
  begin
    pend           = '0;
    pend[SRC_DATA] = DATA_ABORT;
    pend[SRC_FIQ]  = r.fiq_sync[1] && !r.psw[PSW_FMASK_BIT];
    pend[SRC_IRQ]  = r.irq_sync[1] && !r.psw[PSW_IMASK_BIT];
    pend[SRC_PREF] = PREFETCH_ABORT;
    pend[SRC_BAD]  = BAD_OPCODE;
    pend[SRC_TRAP] = SOFTWARE_TRAP && !BAD_OPCODE;
  end

  seu_prio u_prio
  (
    .pend (pend),
    .ent  (ent)
  );

  assign cur_idx = bank_of(r.psw[4:0]);
  assign ent_idx = bank_of(ent.mode);
  assign sp_we   = WR && (ADDR == REG_STACK_PTR || ADDR == REG_BANK_SP);
  assign sp_idx  = (ADDR == REG_BANK_SP) ? r.bank_sel : cur_idx;

  // Banked storage; the entered mode's copies hold the prior context.
  // The save happens on the take edge only, never during the rest cycle, so
  // a source that is still held high cannot overwrite the saved context with
  // the status word of the handler. Software reaches the current bank through
  // the stack pointer index and any bank through the bank select index.
  // A software stack write in the same cycle as an entry goes to the bank of
  // the mode that was current before the entry.
  seu_bank u_bank
  (
    .clk      (CLOCK),
    .rst      (RST),
    .save     (ent.take && r.state == ST_RUN),
    .save_idx (ent_idx),
    .save_psw (r.psw),
    .save_pc  (RETURN_PC),
    .sp_we    (sp_we),
    .sp_idx   (sp_idx),
    .sp_wdata (WDATA),
    .rd_idx   (cur_idx),
    .rd_sp    (cur_sp),
    .rd_psw   (cur_spsr),
    .rd_pc    (cur_spc),
    .aux_idx  (r.bank_sel),
    .aux_sp   (aux_sp)
  );

  // Next-state logic. Entry takes precedence over software writes, so a
  // status write in the same cycle as an exception loses its mode field, state bit and normal mask on purpose.
  always_comb
  begin
    next_r          = r;
    next_r.irq_meta = NORMAL_IRQ;
    next_r.fiq_meta = FAST_IRQ;
    next_r.irq_sync = {r.irq_sync[0], r.irq_meta};
    next_r.fiq_sync = {r.fiq_sync[0], r.fiq_meta};
    next_r.entry    = 1'b0;
    next_r.denied   = 1'b0;
    next_r.rdata    = '0;

    // Read data stands in the cycle after the strobe only.
    // Returning zero outside that cycle lets several units share one return
    // path by a plain OR, at the price of one register stage of latency.
    // Reads have no side effects, so a read of any index is always safe.
    if (RD)
    begin
      case (ADDR)
        REG_PSW:       next_r.rdata = r.psw;
        REG_SAVED_PSW: next_r.rdata = cur_spsr;
        REG_SAVED_PC:  next_r.rdata = cur_spc;
        REG_CONTROL:   next_r.rdata = r.control;
        REG_VECTOR:    next_r.rdata = r.vector;
        REG_STACK_PTR: next_r.rdata = cur_sp;
        REG_BANK_SEL:  next_r.rdata = {29'h0, r.bank_sel};
        REG_BANK_SP:   next_r.rdata = aux_sp;
        default:       next_r.rdata = '0;
      endcase
    end

    // Flags follow the latest arithmetic result.
    // A status word write later in this block overrides the ALU, because the
    // write is the newer intent of software; the two should not collide in a
    // real instruction stream, and this order keeps the outcome defined.
    if (ALU_UPDATE)
      next_r.psw[PSW_NEG_BIT:PSW_OVF_BIT] = ALU_FLAGS;

    // Branch exchange sets the state bit from the target's low bit.
    if (BRANCH_EXCHANGE)
      next_r.psw[PSW_STATE_BIT] = BRANCH_TARGET_LSB;

    if (WR)
    begin
      case (ADDR)
        REG_PSW:
        begin
          // Only privileged code may change the mode field or masks.
          if (is_priv(r.psw[4:0]))
            next_r.psw = WDATA & PSW_WRITABLE;
          else
          begin
            next_r.psw[PSW_NEG_BIT:PSW_OVF_BIT] = WDATA[PSW_NEG_BIT:PSW_OVF_BIT];
            next_r.denied = (WDATA[7:0] != r.psw[7:0]);
          end
        end
        REG_CONTROL:  next_r.control = {31'h0, WDATA[CTRL_HIGH_VEC_BIT]};
        REG_BANK_SEL: next_r.bank_sel = WDATA[2:0];
        default:      next_r.control = r.control;
      endcase
    end

    case (r.state)
      ST_RUN:
      begin
        if (ent.take)
        begin
          // Vector is base plus offset; offset 14h has no source.
          // The high base is honoured although the system has no memory
          // there; keeping the select cleared is a duty of software.
          // Entry always returns to the full instruction state, so every
          // handler starts with the wide instruction set whatever ran before.
          // The fast mask is set only for reset and fast interrupts; every
          // other source leaves it as software last placed it.
          next_r.vector = (r.control[CTRL_HIGH_VEC_BIT] ? VEC_BASE_HIGH : VEC_BASE_LOW)
                          | {24'h0, ent.offset};
          next_r.psw[4:0]           = ent.mode;
          next_r.psw[PSW_IMASK_BIT] = 1'b1;
          if (ent.set_fmask)
            next_r.psw[PSW_FMASK_BIT] = 1'b1;
          next_r.psw[PSW_STATE_BIT] = 1'b0;
          next_r.entry = 1'b1;
          next_r.state = ST_ENTER;
        end
      end
      ST_ENTER:
      begin
        // One cycle of rest lets the sources drop before the next entry.
        next_r.state = ST_RUN;
      end
      default:
      begin
        next_r.state = ST_RUN;
      end
    endcase
  end

  // State register; reset is the highest-priority entry.
  // Reset loads supervisor mode with both masks set and points the vector at
  // the bottom of the low table. It does not pulse the entry output: the
  // core fetches from the reset vector by itself when reset is released.
  // The reset branch assigns only constants, so no stale input can leak in.
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      r          <= '0;
      r.state    <= ST_RUN;
      r.psw      <= PSW_RESET;
      r.control  <= CONTROL_RESET;
      r.vector   <= VEC_BASE_LOW | {24'h0, VEC_RESET};
    end
    else
    begin
      r <= next_r;
    end
  end

  // Outputs.
  // All outputs but the stack pointer come straight from registers. The
  // stack pointer is a read of the bank selected by the current mode, so it
  // follows a mode change in the same cycle as the status word does.
  // The denied pulse tells the core that a user-mode write tried to change
  // the control byte; the flags of that write are still taken.
  assign RDATA               = r.rdata;
  assign ENTRY               = r.entry;
  assign VECTOR_ADDR         = r.vector;
  assign PROGRAM_STATUS_WORD = r.psw;
  assign STACK_POINTER       = cur_sp;
  assign MODE_DENIED         = r.denied;
endmodule : seu_top
